// [design/pcw_config_words.sv]
// register bank for pci configuration words three to fourteen
// ********************
// Behaviour
// - only the latency timer field of the bist/header word is writable
// - bist/header word clears to zero on power-on and software reset
// - latency timer value drives the master bus ownership limit
// - bist bits 29 and 28 always read zero
// - bist support, start and completion code are read-only, zero after reset
// - header byte gives fixed multifunction flag and layout type
// - cache line size unsupported; target cache-disabled, snoop signals ignored
// - io base holds upper address bits matched for io access to local registers
// - narrow io variant: only bits 30 to 20 writable, 19 to 8 zero
// - wide io variant: bits 31 to 8 writable, bits 7 to 2 zero
// - io base resets to space indicator only; bit 1 reads zero
// - memory base 0 bits 31 to 20 writable, limited by size register 0
// - memory bases read fixed prefetch, type and space indicator bits
// - memory base 0 clears on power-on and software reset
// - memory base 1 mirrors base 0 using size register 1
// - memory base 1 clears on power-on and software reset
// - words 7 to 10, 12 and 14 read as zero
// - subsystem word writable from local bus, kept through reset
// - capability pointer read-only, upper zero, low byte fixed offset
// ********************
`timescale 1ns/1ps
module pcw_config_words #(
  parameter bit WIDE_IO = 1'b1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic soft_reset_i,
  // pci configuration access
  input wire logic pci_wr_i,
  input wire logic [3:0] pci_word_i,
  input wire logic [31:0] pci_wdata_i,
  input wire logic [3:0] pci_be_i,
  // local peripheral bus access
  input wire logic lpb_wr_i,
  input wire logic [3:0] lpb_word_i,
  input wire logic [31:0] lpb_wdata_i,
  input wire logic [3:0] lpb_be_i,
  // read port shared by both buses
  input wire logic [3:0] rd_word_i,
  output logic [31:0] rd_data_o,
  // local space size codes, same clock domain
  input wire logic [3:0] space0_size_i,
  input wire logic [3:0] space1_size_i,
  // decoded window state
  output logic [7:0] master_latency_timer_o,
  output logic [31:0] io_window_base_o,
  output logic [31:0] memory_window0_base_o,
  output logic [31:0] memory_window1_base_o,
  output logic cache_disabled_o
);
  // ********************
  // helpers
  // ********************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic word_hit(input logic en, input logic [3:0] word, input logic [3:0] target);
    return en && (word == target);
  endfunction : word_hit

  function automatic logic [31:0] mem_base(input logic [pcw_pkg::MEM_BITS-1:0] b);
    return {b, {pcw_pkg::MEM_LSB{1'b0}}};
  endfunction : mem_base

  // ********************
  // write selection, local bus has priority on a collision
  // ********************
  logic wr;
  logic [3:0] wr_word;
  logic [31:0] wr_data;
  logic [3:0] wr_be;
  assign wr = pci_wr_i | lpb_wr_i;
  assign wr_word = lpb_wr_i ? lpb_word_i : pci_word_i;
  assign wr_data = lpb_wr_i ? lpb_wdata_i : pci_wdata_i;
  assign wr_be = lpb_wr_i ? lpb_be_i : pci_be_i;

  localparam int IO_WIDE_LSB_C = pcw_pkg::IO_WIDE_LSB;
  localparam int IO_NARROW_LSB_C = pcw_pkg::IO_NARROW_LSB;
  localparam int IO_NARROW_MSB_C = pcw_pkg::IO_NARROW_MSB;
  localparam int MEM_BITS_C = pcw_pkg::MEM_BITS;

  // ********************
  // elaboration checks
  // ********************
  if (IO_NARROW_MSB_C != 30 || IO_NARROW_LSB_C <= IO_WIDE_LSB_C) begin : g_bad_io_layout
    $error("io base field layout not supported");
  end
  if (pcw_pkg::MEM_LSB + MEM_BITS_C != 32) begin : g_bad_mem_layout
    $error("memory base field must end at bit 31");
  end

  // ********************
  // io base write mask
  // ********************
  logic [31:0] io_mask;
  assign io_mask = WIDE_IO ? {{(32-IO_WIDE_LSB_C){1'b1}}, {IO_WIDE_LSB_C{1'b0}}}
                           : {1'b0, {(IO_NARROW_MSB_C-IO_NARROW_LSB_C+1){1'b1}}, {IO_NARROW_LSB_C{1'b0}}};

  // ********************
  // per-word write strobes
  // ********************
  logic lat_wr;
  logic io_wr;
  logic mem0_wr;
  logic mem1_wr;
  logic subsys_wr;
  assign lat_wr = word_hit(wr, wr_word, pcw_pkg::WORD_BIST_HDR);
  assign io_wr = word_hit(wr, wr_word, pcw_pkg::WORD_IO_BASE);
  assign mem0_wr = word_hit(wr, wr_word, pcw_pkg::WORD_MEM0_BASE);
  assign mem1_wr = word_hit(wr, wr_word, pcw_pkg::WORD_MEM1_BASE);
  assign subsys_wr = word_hit(lpb_wr_i, lpb_word_i, pcw_pkg::WORD_SUBSYS);

  // ********************
  // window masks from size codes
  // ********************
  logic [MEM_BITS_C-1:0] keep0;
  logic [MEM_BITS_C-1:0] keep1;
  pcw_window_mask #(.BITS(MEM_BITS_C)) u_mask0 (
    .size_code_i(space0_size_i),
    .keep_o(keep0)
  );
  pcw_window_mask #(.BITS(MEM_BITS_C)) u_mask1 (
    .size_code_i(space1_size_i),
    .keep_o(keep1)
  );

  // ********************
  // latency timer
  // ********************
  logic [7:0] lat_q;
  logic [31:0] lat_merged;
  assign lat_merged = merge({16'h0000, lat_q, 8'h00}, wr_data, wr_be);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lat_q <= pcw_pkg::LAT_RESET;
    end else if (soft_reset_i) begin
      lat_q <= pcw_pkg::LAT_RESET;
    end else if (lat_wr) begin
      lat_q <= lat_merged[pcw_pkg::LAT_MSB:pcw_pkg::LAT_LSB];
    end
  end

  // ********************
  // io base
  // ********************
  logic [31:0] io_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_q <= pcw_pkg::IO_BASE_RESET;
    end else if (soft_reset_i) begin
      io_q <= pcw_pkg::IO_BASE_RESET;
    end else if (io_wr) begin
      io_q <= (merge(io_q, wr_data, wr_be) & io_mask) | pcw_pkg::IO_BASE_RESET;
    end
  end

  // ********************
  // memory bases
  // ********************
  logic [MEM_BITS_C-1:0] mem0_q;
  logic [MEM_BITS_C-1:0] mem1_q;
  logic [31:0] mem0_merged;
  logic [31:0] mem1_merged;
  assign mem0_merged = merge(mem_base(mem0_q), wr_data, wr_be);
  assign mem1_merged = merge(mem_base(mem1_q), wr_data, wr_be);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem0_q <= '0;
    end else if (soft_reset_i) begin
      mem0_q <= '0;
    end else if (mem0_wr) begin
      mem0_q <= mem0_merged[31:pcw_pkg::MEM_LSB] & keep0;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem1_q <= '0;
    end else if (soft_reset_i) begin
      mem1_q <= '0;
    end else if (mem1_wr) begin
      mem1_q <= mem1_merged[31:pcw_pkg::MEM_LSB] & keep1;
    end
  end

  // ********************
  // subsystem identity, local bus only, no reset
  // ********************
  logic [31:0] subsys_q;
  always_ff @(posedge clk_i) begin
    if (subsys_wr) begin
      subsys_q <= merge(subsys_q, lpb_wdata_i, lpb_be_i);
    end
  end

  // ********************
  // read mux
  // ********************
  logic [31:0] rd_d;
  always_comb begin
    case (rd_word_i)
      pcw_pkg::WORD_BIST_HDR: begin
        // bist byte all fixed zero, header and cache bytes fixed
        rd_d = {pcw_pkg::FIXED_BIST_BYTE, pcw_pkg::FIXED_HEADER_BYTE, lat_q, pcw_pkg::FIXED_CACHE_BYTE};
      end
      pcw_pkg::WORD_IO_BASE: rd_d = io_q;
      pcw_pkg::WORD_MEM0_BASE: rd_d = {mem0_q, 16'h0000, pcw_pkg::FIXED_MEM_ATTR};
      pcw_pkg::WORD_MEM1_BASE: rd_d = {mem1_q, 16'h0000, pcw_pkg::FIXED_MEM_ATTR};
      pcw_pkg::WORD_SUBSYS: rd_d = subsys_q;
      pcw_pkg::WORD_CAP_PTR: rd_d = {24'h000000, pcw_pkg::CAP_OFFSET};
      default: rd_d = pcw_pkg::ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o <= pcw_pkg::ZERO_WORD;
    end else begin
      rd_data_o <= rd_d;
    end
  end

  // ********************
  // registered state outputs, one flop group per output
  // ********************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      master_latency_timer_o <= pcw_pkg::LAT_RESET;
    end else begin
      master_latency_timer_o <= lat_q;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_window_base_o <= pcw_pkg::IO_BASE_RESET;
    end else begin
      io_window_base_o <= io_q;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      memory_window0_base_o <= pcw_pkg::MEM_BASE_RESET;
    end else begin
      memory_window0_base_o <= mem_base(mem0_q);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      memory_window1_base_o <= pcw_pkg::MEM_BASE_RESET;
    end else begin
      memory_window1_base_o <= mem_base(mem1_q);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cache_disabled_o <= 1'b1;
    end else begin
      cache_disabled_o <= 1'b1;
    end
  end
endmodule : pcw_config_words

// [design/pcw_pkg.sv]
// constants for the pci configuration words three to fourteen
package pcw_pkg;
  // ********************
  // word indices
  // ********************
  localparam logic [3:0] WORD_BIST_HDR = 4'h3;
  localparam logic [3:0] WORD_IO_BASE = 4'h4;
  localparam logic [3:0] WORD_MEM0_BASE = 4'h5;
  localparam logic [3:0] WORD_MEM1_BASE = 4'h6;
  localparam logic [3:0] WORD_SUBSYS = 4'hB;
  localparam logic [3:0] WORD_CAP_PTR = 4'hD;
  // ********************
  // field layout
  // ********************
  localparam int LAT_LSB = 8;
  localparam int LAT_MSB = 15;
  localparam int IO_WIDE_LSB = 8;
  localparam int IO_NARROW_LSB = 20;
  localparam int IO_NARROW_MSB = 30;
  localparam int MEM_LSB = 20;
  localparam int MEM_BITS = 12;
  // ********************
  // reset and fixed values
  // ********************
  localparam logic [31:0] BIST_HDR_RESET = 32'h0000_0000;
  localparam logic [31:0] IO_BASE_RESET = 32'h0000_0001;
  localparam logic [31:0] MEM_BASE_RESET = 32'h0000_0000;
  localparam logic [7:0] CAP_OFFSET = 8'h40;
  localparam logic [7:0] FIXED_BIST_BYTE = 8'h00;
  localparam logic [7:0] FIXED_HEADER_BYTE = 8'h00;
  localparam logic [7:0] FIXED_CACHE_BYTE = 8'h00;
  localparam logic [3:0] FIXED_MEM_ATTR = 4'h0;
  localparam logic [7:0] LAT_RESET = 8'h00;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : pcw_pkg

// [design/pcw_window_mask.sv]
// turns a local space size code into a mask of valid memory base bits
`timescale 1ns/1ps
module pcw_window_mask #(
  parameter int BITS = 12
) (
  input wire logic [3:0] size_code_i,
  output logic [BITS-1:0] keep_o
);
  if (BITS < 1 || BITS > 16) begin : g_bad_bits
    $error("mask width must be 1 to 16 bits");
  end

  // size code n: the low n bits of the base field do not hold a value
  always_comb begin
    keep_o = '1;
    for (int i = 0; i < BITS; i++) begin
      if (i < int'(size_code_i)) begin
        keep_o[i] = 1'b0;
      end
    end
  end
endmodule : pcw_window_mask

// [sim/pcw_config_words_monitor.sv]
// checker for the configuration word bank
`timescale 1ns/1ps
module pcw_config_words_monitor #(
  parameter bit WIDE_IO = 1'b1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic soft_reset_i,
  input wire logic lpb_wr_i,
  input wire logic [3:0] lpb_word_i,
  input wire logic [31:0] lpb_wdata_i,
  input wire logic [3:0] lpb_be_i,
  input wire logic [3:0] rd_word_i,
  input wire logic [31:0] rd_data_o,
  input wire logic [7:0] master_latency_timer_o,
  input wire logic [31:0] io_window_base_o,
  input wire logic [31:0] memory_window0_base_o,
  input wire logic [31:0] memory_window1_base_o,
  input wire logic cache_disabled_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_soft;
    soft_reset_i;
  endsequence
  sequence s_lat_wr;
    lpb_wr_i && lpb_word_i == 4'h3 && lpb_be_i[1] && !soft_reset_i;
  endsequence
  sequence s_io_wr;
    WIDE_IO && lpb_wr_i && lpb_word_i == 4'h4 && lpb_be_i == 4'hF && !soft_reset_i;
  endsequence
  AST_CACHE_OFF: assert property (cache_disabled_o) else $error("cache flag low");
  AST_LAT_WR: assert property (s_lat_wr |-> ##2 master_latency_timer_o == $past(lpb_wdata_i[15:8], 2))
    else $error("latency not stored");
  AST_IO_WR: assert property (s_io_wr |-> ##2 io_window_base_o[31:8] == $past(lpb_wdata_i[31:8], 2))
    else $error("io base not stored");
  AST_LAT_RST: assert property (s_soft |-> ##2 master_latency_timer_o == 8'h00) else $error("latency kept");
  AST_IO_RST: assert property (s_soft |-> ##2 io_window_base_o == 32'h0000_0001) else $error("io kept");
  AST_MEM_RST: assert property (s_soft |-> ##2 (memory_window0_base_o | memory_window1_base_o) == 32'h0)
    else $error("mem kept");
  AST_IO_FIXED: assert property (WIDE_IO ? io_window_base_o[7:0] == 8'h01
                                         : io_window_base_o[31] == 1'b0 && io_window_base_o[19:0] == 20'h00001)
    else $error("io low bits");
  AST_MEM_LOW: assert property ((memory_window0_base_o[19:0] | memory_window1_base_o[19:0]) == 20'h0)
    else $error("mem low bits");
  AST_RD_BIST: assert property (rd_word_i == 4'h3 |=> rd_data_o[31:16] == 16'h0 && rd_data_o[7:0] == 8'h0)
    else $error("fixed bytes");
  AST_RD_RSVD: assert property (rd_word_i inside {4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hE} |=> rd_data_o == 32'h0)
    else $error("reserved word");
  AST_RD_CAP: assert property (rd_word_i == 4'hD |=> rd_data_o == 32'h0000_0040) else $error("cap word");
endmodule : pcw_config_words_monitor
bind pcw_config_words pcw_config_words_monitor #(.WIDE_IO(WIDE_IO)) mon (.clk_i(clk_i), .resetn_i(resetn_i),
  .soft_reset_i(soft_reset_i), .lpb_wr_i(lpb_wr_i), .lpb_word_i(lpb_word_i), .lpb_wdata_i(lpb_wdata_i),
  .lpb_be_i(lpb_be_i), .rd_word_i(rd_word_i), .rd_data_o(rd_data_o),
  .master_latency_timer_o(master_latency_timer_o), .io_window_base_o(io_window_base_o),
  .memory_window0_base_o(memory_window0_base_o), .memory_window1_base_o(memory_window1_base_o),
  .cache_disabled_o(cache_disabled_o));

// [sim/pcw_host_model.sv]
// pci host model issuing configuration writes
`timescale 1ns/1ps
module pcw_host_model (
  input wire logic clk_i,
  output logic pci_wr_o,
  output logic [3:0] pci_word_o,
  output logic [31:0] pci_wdata_o,
  output logic [3:0] pci_be_o
);
  initial {pci_wr_o, pci_word_o, pci_wdata_o, pci_be_o} = '0;
  // windows set up before any transfer uses them
  task automatic cfg_wr(input logic [3:0] w, input logic [31:0] d, input logic [3:0] be);
    pci_wr_o <= 1'b1;
    pci_word_o <= w;
    pci_wdata_o <= d;
    pci_be_o <= be;
    @(posedge clk_i);
    pci_wr_o <= 1'b0;
    pci_wdata_o <= ~d;
  endtask : cfg_wr
endmodule : pcw_host_model

// [sim/pcw_config_words_tb.sv]
// self-checking bench for the configuration word bank
`timescale 1ns/1ps
module pcw_config_words_tb;
  logic clk_i = 1'b0, resetn_i = 1'b0, soft_reset_i = 1'b0, lpb_wr_i = 1'b0, pci_wr_i, cache_disabled_o;
  logic [3:0] lpb_word_i = 4'h0, lpb_be_i = 4'h0, rd_word_i = 4'h0, pci_word_i, pci_be_i, wsel;
  logic [3:0] space0_size_i = 4'h0, space1_size_i = 4'h4;
  logic [31:0] lpb_wdata_i = 32'h0, pci_wdata_i, rd_data_o, io_window_base_o, memory_window0_base_o;
  logic [31:0] memory_window1_base_o, rnd = 32'h0000_F310;
  logic [31:0] rd_data_n, io_base_n, shadow_n = 32'h0000_0001;
  logic [31:0] shadow [16];
  logic [7:0] master_latency_timer_o;
  int num_errors = 0;
  int samples_checked = 0;
  always #4 clk_i = ~clk_i;
  pcw_config_words #(.WIDE_IO(1'b1)) DUT (.clk_i(clk_i), .resetn_i(resetn_i), .soft_reset_i(soft_reset_i),
    .pci_wr_i(pci_wr_i), .pci_word_i(pci_word_i), .pci_wdata_i(pci_wdata_i), .pci_be_i(pci_be_i),
    .lpb_wr_i(lpb_wr_i), .lpb_word_i(lpb_word_i), .lpb_wdata_i(lpb_wdata_i), .lpb_be_i(lpb_be_i),
    .rd_word_i(rd_word_i), .rd_data_o(rd_data_o), .space0_size_i(space0_size_i), .space1_size_i(space1_size_i),
    .master_latency_timer_o(master_latency_timer_o), .io_window_base_o(io_window_base_o),
    .memory_window0_base_o(memory_window0_base_o), .memory_window1_base_o(memory_window1_base_o),
    .cache_disabled_o(cache_disabled_o));
  pcw_config_words #(.WIDE_IO(1'b0)) DUT_NARROW (.clk_i(clk_i), .resetn_i(resetn_i), .soft_reset_i(soft_reset_i),
    .pci_wr_i(pci_wr_i), .pci_word_i(pci_word_i), .pci_wdata_i(pci_wdata_i), .pci_be_i(pci_be_i),
    .lpb_wr_i(lpb_wr_i), .lpb_word_i(lpb_word_i), .lpb_wdata_i(lpb_wdata_i), .lpb_be_i(lpb_be_i),
    .rd_word_i(rd_word_i), .rd_data_o(rd_data_n), .space0_size_i(space0_size_i), .space1_size_i(space1_size_i),
    .master_latency_timer_o(), .io_window_base_o(io_base_n), .memory_window0_base_o(),
    .memory_window1_base_o(), .cache_disabled_o());
  pcw_host_model host (.clk_i(clk_i), .pci_wr_o(pci_wr_i), .pci_word_o(pci_word_i), .pci_wdata_o(pci_wdata_i),
    .pci_be_o(pci_be_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] exp_word(input logic [3:0] w, input logic [31:0] d);
    case (w)
      4'h3: return {16'h0000, d[15:8], 8'h00};
      4'h4: return {d[31:8], 8'h01};
      4'h5: return {d[31:20], 20'h00000};
      4'h6: return {d[31:24], 24'h000000};
      4'hB: return d;
      4'hD: return 32'h0000_0040;
      default: return 32'h0000_0000;
    endcase
  endfunction : exp_word
  function automatic logic [31:0] exp_io_narrow(input logic [31:0] d);
    return {1'b0, d[30:20], 20'h00001};
  endfunction : exp_io_narrow
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input bit pci, input logic [3:0] w, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_i);
    if (pci) begin
      host.cfg_wr(w, d, be);
    end else begin
      lpb_wr_i <= 1'b1;
      lpb_word_i <= w;
      lpb_wdata_i <= d;
      lpb_be_i <= be;
      @(posedge clk_i);
      lpb_wr_i <= 1'b0;
      lpb_wdata_i <= ~d;
    end
  endtask : wr
  task automatic rd(input logic [3:0] w);
    @(posedge clk_i);
    rd_word_i <= w;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask : rd
  task automatic check_all;
    for (int k = 3; k < 15; k++) begin
      rd(k[3:0]);
      chk(rd_data_o, shadow[k]);
      chk(rd_data_n, (k == 4) ? shadow_n : shadow[k]);
    end
  endtask : check_all
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  initial begin
    for (int k = 0; k < 16; k++) shadow[k] = exp_word(k[3:0], 32'h0);
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    wr(1'b0, 4'hB, 32'hA5C3_1E2D, 4'hF);
    shadow[11] = 32'hA5C3_1E2D;
    check_all;
    chk({31'h0, cache_disabled_o}, 32'h1);
    $display("defaults done");
    for (int i = 0; i < 60; i++) begin
      rnd = lfsr(rnd);
      wsel = rnd[7:4] % 4'hC + 4'h3;
      wr(rnd[8], wsel, lfsr(rnd), 4'hF);
      if (!(rnd[8] && wsel == 4'hB)) shadow[wsel] = exp_word(wsel, lfsr(rnd));
      if (wsel == 4'h4) shadow_n = exp_io_narrow(lfsr(rnd));
      rd(wsel);
      chk(rd_data_o, shadow[wsel]);
      chk(rd_data_n, (wsel == 4'h4) ? shadow_n : shadow[wsel]);
    end
    wr(1'b0, 4'h3, 32'hFFFF_FFFF, 4'hD);
    rd(4'h3);
    chk(rd_data_o, shadow[3]);
    chk({24'h0, master_latency_timer_o}, {24'h0, shadow[3][15:8]});
    chk(io_window_base_o, shadow[4]);
    chk(memory_window1_base_o, shadow[6]);
    chk(memory_window0_base_o, shadow[5]);
    chk(io_base_n, shadow_n);
    $display("random done");
    @(posedge clk_i);
    soft_reset_i <= 1'b1;
    @(posedge clk_i);
    soft_reset_i <= 1'b0;
    for (int k = 3; k < 7; k++) shadow[k] = exp_word(k[3:0], 32'h0);
    shadow_n = 32'h0000_0001;
    check_all;
    wr(1'b1, 4'h5, 32'hFFFF_FFFF, 4'hF);
    shadow[5] = exp_word(4'h5, 32'hFFFF_FFFF);
    rd(4'h5);
    chk(rd_data_o, shadow[5]);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    @(negedge clk_i);
    chk(io_window_base_o, 32'h0000_0001);
    chk(memory_window0_base_o, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    shadow[5] = exp_word(4'h5, 32'h0);
    check_all;
    $display("resets done");
    close_out;
  end
endmodule : pcw_config_words_tb
